/* File: rtl/scha_defs.svh */
// Offsets, field positions, reset values and timing counts of the host access block
`ifndef SCHA_DEFS_SVH
`define SCHA_DEFS_SVH

// ==========================================================================
// SPI commands
`define SCHA_CMD_READ       8'h03
`define SCHA_CMD_WRITE      8'h02
`define SCHA_STRAP_SPI      2'h2

// ==========================================================================
// Register indices and fields
`define SCHA_IDX_CHIP_ID    8'h00
`define SCHA_IDX_START      8'h01
`define SCHA_IDX_GCTRL      8'h0c
`define SCHA_START_BIT      0
`define SCHA_SPEED_MSB      5
`define SCHA_SPEED_LSB      4
`define SCHA_SPEED_FAST     2'h2
`define SCHA_REG1_RST       8'h40
`define SCHA_GCTRL_RST      8'h00

// ==========================================================================
// Management frame fields
`define SCHA_PREAMBLE_LEN   6'h20
`define SCHA_OP_READ        2'h2
`define SCHA_OP_WRITE       2'h1
`define SCHA_EXT_SEL        2'h3
`define SCHA_PHY_REG_LAST   5'h05
`define SCHA_PHY_REG_1D     5'h1d
`define SCHA_PHY_REG_1F     5'h1f

// ==========================================================================
// Timing
`define SCHA_CLK_MHZ        10
`define SCHA_INIT_US        100
`define SCHA_INIT_CYCLES    (`SCHA_INIT_US * `SCHA_CLK_MHZ)

`endif

/* File: rtl/scha_pkg.sv */
// Types shared by the host access block
package scha_pkg;

  // ========================================================================
  // State machines
  typedef enum logic [1:0] {
    spi_st_cmd,
    spi_st_addr,
    spi_st_data,
    spi_st_ignore
  } scha_spi_state_type;

  typedef enum logic [2:0] {
    mdio_st_pre,
    mdio_st_start,
    mdio_st_op,
    mdio_st_phy,
    mdio_st_reg,
    mdio_st_ta,
    mdio_st_data
  } scha_mdio_state_type;

endpackage : scha_pkg

/* File: rtl/scha_sync2.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps

module scha_sync2 #(
  parameter int               WIDTH   = 7,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // ========================================================================
  // One pair of flops per bit; meta feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta[i]   <= RST_VAL[i];
        sync_o[i] <= RST_VAL[i];
      end else begin
        meta[i]   <= async_i[i];
        sync_o[i] <= meta[i];
      end
    end
  end

endmodule : scha_sync2

/* File: rtl/scha_regmem.sv */
// 256 x 8 configuration register store with registered read data
`timescale 1ns/1ps

module scha_regmem (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);

  logic [7:0] mem [0:255];

  // ========================================================================
  // Array has no reset: unwritten entries read undefined
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (re_i) begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule : scha_regmem

/* File: rtl/scha_top.sv */
// SPI slave and MDC/MDIO host access to the switch configuration registers
//
// Contract
// - SPI byte 03h reads, 02h writes, then address.
// - SPI reaches every register index 0 to 255.
// - Address increments after each byte while selected.
// - Deselect ends operation; reselect before new command.
// - Auto-increment address wraps from 255 to 0.
// - Fast SPI only after speed field set 10.
// - Serial input sampled on rising clock edge.
// - Read data launched on falling clock edge.
// - Start bit cleared, switching held off after reset.
// - Switching starts when host writes start bit.
// - Frame: preamble, start, opcode, addresses, turnaround, data.
// - Management clock at most 10 MHz; MDC here must stay well below clock_i / 4, 2.5 MHz at the 10 MHz clock.
// - Standard frames reach only PHY registers listed.
// - Opcode 10 with address bits 11: extended read.
// - Opcode 01 with address bits 11: extended write.
// - Extended index from PHY bits 4,3,0 and register.
// - Read turnaround: host releases, device drives 0.
// - Extended read returns byte, upper data zero.
// - Extended write keeps low byte, ignores upper.
// - Extended access reaches all 256 registers.
`timescale 1ns/1ps
`include "scha_defs.svh"

module scha_top import scha_pkg::*; #(
  // Identification value is arbitrary
  parameter logic [7:0] CHIP_ID = 8'h5a
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [1:0]  serial_port_strap_i,
  input  wire logic        slave_select_n_i,
  input  wire logic        serial_clock_in_i,
  input  wire logic        serial_data_in_i,
  output logic             serial_data_out_o,
  output logic             serial_data_out_oe_o,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  output logic             phy_req_o,
  output logic             phy_we_o,
  output logic [4:0]       phy_addr_field_o,
  output logic [4:0]       reg_addr_field_o,
  output logic [15:0]      phy_wdata_o,
  input  wire logic [15:0] phy_rdata_i,
  output logic             start_switch_o,
  output logic             spi_fast_o,
  output logic             config_ready_o
);

  // ==========================================================================
  // Pin synchronisers and edge detection
  logic [6:0] sync_q;
  logic [1:0] strap_s;
  logic       ss_n_s, sck_s, sdi_s, mdc_s, mdio_s;
  logic       sck_d, mdc_d, sck_rise, sck_fall, mdc_rise;

  // Reset to idle pin levels so no false clock edge follows reset
  scha_sync2 #(.WIDTH(7), .RST_VAL(7'h1b)) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i ({serial_port_strap_i, slave_select_n_i, serial_clock_in_i,
               serial_data_in_i, mdc_i, mdio_i}),
    .sync_o  (sync_q)
  );

  assign strap_s = sync_q[6:5];
  assign ss_n_s  = sync_q[4];
  assign sck_s   = sync_q[3];
  assign sdi_s   = sync_q[2];
  assign mdc_s   = sync_q[1];
  assign mdio_s  = sync_q[0];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_d <= 1'b1;
      mdc_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      mdc_d <= mdc_s;
    end
  end

  // Oversampled clocks: pin clocks must stay well below clock_i / 4
  // limited pin clock
  assign mdc_rise = mdc_s & ~mdc_d;
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;

  // ==========================================================================
  // Start-up window and strap capture
  logic [9:0] init_cnt;
  logic       init_done;
  logic       spi_mode;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_cnt  <= 10'h000;
      init_done <= 1'b0;
    end else if (!init_done) begin
      if (init_cnt == 10'(`SCHA_INIT_CYCLES - 1)) begin
        init_done <= 1'b1;
      end
      init_cnt <= init_cnt + 10'h001;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_mode <= 1'b0;
    end else if (!init_done) begin
      spi_mode <= (strap_s == `SCHA_STRAP_SPI);
    end
  end

  assign config_ready_o = init_done;

  // ==========================================================================
  // Register store arbitration, SPI ahead of MDIO
  logic       spi_pend, spi_we, mdio_pend, mdio_we;
  logic [7:0] spi_maddr, spi_wdata, mdio_maddr, mdio_wdata;
  logic       grant_spi, grant_mdio, mem_we, mem_re;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, rd_addr_q, rd_data;
  logic       rd_to_spi, rd_to_mdio;
  logic [7:0] reg_start, reg_gctrl;

  assign grant_spi  = spi_pend;
  assign grant_mdio = mdio_pend & ~spi_pend;
  assign mem_we     = (grant_spi & spi_we) | (grant_mdio & mdio_we);
  assign mem_re     = (grant_spi & ~spi_we) | (grant_mdio & ~mdio_we);
  assign mem_addr   = grant_spi ? spi_maddr : mdio_maddr;
  assign mem_wdata  = grant_spi ? spi_wdata : mdio_wdata;

  scha_regmem u_mem (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .we_i    (mem_we),
    .re_i    (mem_re),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_to_spi  <= 1'b0;
      rd_to_mdio <= 1'b0;
      rd_addr_q  <= 8'h00;
    end else begin
      rd_to_spi  <= grant_spi & ~spi_we;
      rd_to_mdio <= grant_mdio & ~mdio_we;
      rd_addr_q  <= mem_addr;
    end
  end

  // Control registers live beside the store so they have reset values
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_start <= `SCHA_REG1_RST;
      reg_gctrl <= `SCHA_GCTRL_RST;
    end else if (mem_we) begin
      if (mem_addr == `SCHA_IDX_START) begin
        reg_start <= mem_wdata;
      end
      if (mem_addr == `SCHA_IDX_GCTRL) begin
        reg_gctrl <= mem_wdata;
      end
    end
  end

  always_comb begin
    if (rd_addr_q == `SCHA_IDX_CHIP_ID) begin
      rd_data = CHIP_ID;
    end else if (rd_addr_q == `SCHA_IDX_START) begin
      rd_data = reg_start;
    end else if (rd_addr_q == `SCHA_IDX_GCTRL) begin
      rd_data = reg_gctrl;
    end else begin
      rd_data = mem_rdata;
    end
  end

  assign start_switch_o = reg_start[`SCHA_START_BIT] & init_done;
  assign spi_fast_o = (reg_gctrl[`SCHA_SPEED_MSB:`SCHA_SPEED_LSB] == `SCHA_SPEED_FAST);

  // ==========================================================================
  // SPI slave
  scha_spi_state_type spi_state;
  logic [2:0] spi_bits;
  logic [6:0] spi_shift;
  logic       spi_is_read, spi_done;
  logic [7:0] spi_byte, spi_addr, spi_tx, spi_tx_next;

  assign spi_byte = {spi_shift, sdi_s};
  assign spi_done = sck_rise & ~ss_n_s & spi_mode & (spi_bits == 3'h7);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_state   <= spi_st_cmd;
      spi_bits    <= 3'h0;
      spi_shift   <= 7'h00;
      spi_is_read <= 1'b0;
    end else if (ss_n_s | ~spi_mode) begin
      spi_state <= spi_st_cmd;
      spi_bits  <= 3'h0;
    end else if (sck_rise) begin
      spi_bits  <= spi_bits + 3'h1;
      spi_shift <= spi_byte[6:0];
      if (spi_done) begin
        unique case (spi_state)
          spi_st_cmd: begin
            if (spi_byte == `SCHA_CMD_READ) begin
              spi_state   <= spi_st_addr;
              spi_is_read <= 1'b1;
            end else if (spi_byte == `SCHA_CMD_WRITE) begin
              spi_state   <= spi_st_addr;
              spi_is_read <= 1'b0;
            end else begin
              spi_state <= spi_st_ignore;
            end
          end
          spi_st_addr:   spi_state <= spi_st_data;
          spi_st_data:   spi_state <= spi_st_data;
          spi_st_ignore: spi_state <= spi_st_ignore;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_addr <= 8'h00;
    end else if (spi_done && spi_state == spi_st_addr) begin
      spi_addr <= spi_byte;
    end else if (spi_done && spi_state == spi_st_data) begin
      spi_addr <= spi_addr + 8'h01;
    end
  end

  // Read prefetches the next byte so it is ready at the falling edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_pend  <= 1'b0;
      spi_we    <= 1'b0;
      spi_maddr <= 8'h00;
      spi_wdata <= 8'h00;
    end else if (spi_done && spi_state == spi_st_addr && spi_is_read) begin
      spi_pend  <= 1'b1;
      spi_we    <= 1'b0;
      spi_maddr <= spi_byte;
    end else if (spi_done && spi_state == spi_st_data) begin
      spi_pend  <= 1'b1;
      spi_we    <= ~spi_is_read;
      spi_maddr <= spi_is_read ? spi_addr + 8'h01 : spi_addr;
      spi_wdata <= spi_byte;
    end else if (grant_spi) begin
      spi_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_tx_next       <= 8'h00;
      spi_tx            <= 8'h00;
      serial_data_out_o <= 1'b0;
    end else begin
      if (rd_to_spi) begin
        spi_tx_next <= rd_data;
      end
      if (sck_fall && spi_state == spi_st_data && spi_is_read && !ss_n_s) begin
        if (spi_bits == 3'h0) begin
          serial_data_out_o <= spi_tx_next[7];
          spi_tx            <= {spi_tx_next[6:0], 1'b0};
        end else begin
          serial_data_out_o <= spi_tx[7];
          spi_tx            <= {spi_tx[6:0], 1'b0};
        end
      end
    end
  end

  assign serial_data_out_oe_o = ~ss_n_s & spi_mode & spi_is_read & (spi_state == spi_st_data);

  // ==========================================================================
  // MDC/MDIO management port
  scha_mdio_state_type mstate;
  logic [5:0]  pre_cnt;
  logic [3:0]  mbits;
  logic [1:0]  mop;
  logic [4:0]  mphy, mreg, reg_next;
  logic [15:0] mrx, mtx, mrx_next;
  logic        m_ext, reg_done, data_done, phy_rd_q;
  logic [7:0]  ext_idx;

  function automatic logic phy_reg_ok(input logic [4:0] r);
    phy_reg_ok = (r <= `SCHA_PHY_REG_LAST) || (r == `SCHA_PHY_REG_1D) || (r == `SCHA_PHY_REG_1F);
  endfunction : phy_reg_ok

  assign reg_next  = {mreg[3:0], mdio_s};
  assign mrx_next  = {mrx[14:0], mdio_s};
  assign m_ext     = (mphy[2:1] == `SCHA_EXT_SEL);
  assign reg_done  = mdc_rise & (mstate == mdio_st_reg) & (mbits == 4'h4);
  assign data_done = mdc_rise & (mstate == mdio_st_data) & (mbits == 4'hf);
  assign ext_idx   = {mphy[4:3], mphy[0], reg_done ? reg_next : mreg};

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mstate  <= mdio_st_pre;
      pre_cnt <= 6'h00;
      mbits   <= 4'h0;
      mop     <= 2'h0;
      mphy    <= 5'h00;
      mreg    <= 5'h00;
      mrx     <= 16'h0000;
    end else if (mdc_rise) begin
      mbits <= mbits + 4'h1;
      unique case (mstate)
        mdio_st_pre: begin
          mbits <= 4'h0;
          if (mdio_s) begin
            pre_cnt <= (pre_cnt == `SCHA_PREAMBLE_LEN) ? pre_cnt : pre_cnt + 6'h01;
          end else begin
            pre_cnt <= 6'h00;
            mstate  <= (pre_cnt == `SCHA_PREAMBLE_LEN) ? mdio_st_start : mdio_st_pre;
          end
        end
        mdio_st_start: begin
          mbits  <= 4'h0;
          mstate <= mdio_s ? mdio_st_op : mdio_st_pre;
        end
        mdio_st_op: begin
          mop <= {mop[0], mdio_s};
          if (mbits == 4'h1) begin
            mbits  <= 4'h0;
            mstate <= mdio_st_phy;
          end
        end
        mdio_st_phy: begin
          mphy <= {mphy[3:0], mdio_s};
          if (mbits == 4'h4) begin
            mbits  <= 4'h0;
            mstate <= mdio_st_reg;
          end
        end
        mdio_st_reg: begin
          mreg <= reg_next;
          if (mbits == 4'h4) begin
            mbits  <= 4'h0;
            mstate <= (mop == `SCHA_OP_READ || mop == `SCHA_OP_WRITE) ? mdio_st_ta : mdio_st_pre;
          end
        end
        mdio_st_ta: begin
          if (mbits == 4'h1) begin
            mbits  <= 4'h0;
            mstate <= mdio_st_data;
          end
        end
        mdio_st_data: begin
          mrx <= mrx_next;
          if (mbits == 4'hf) begin
            mstate <= mdio_st_pre;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdio_pend  <= 1'b0;
      mdio_we    <= 1'b0;
      mdio_maddr <= 8'h00;
      mdio_wdata <= 8'h00;
    end else if (reg_done && mop == `SCHA_OP_READ && m_ext) begin
      mdio_pend  <= 1'b1;
      mdio_we    <= 1'b0;
      mdio_maddr <= ext_idx;
    end else if (data_done && mop == `SCHA_OP_WRITE && m_ext) begin
      mdio_pend  <= 1'b1;
      mdio_we    <= 1'b1;
      mdio_maddr <= ext_idx;
      mdio_wdata <= mrx_next[7:0];
    end else if (grant_mdio) begin
      mdio_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_req_o        <= 1'b0;
      phy_we_o         <= 1'b0;
      phy_addr_field_o <= 5'h00;
      reg_addr_field_o <= 5'h00;
      phy_wdata_o      <= 16'h0000;
      phy_rd_q         <= 1'b0;
    end else begin
      phy_req_o <= 1'b0;
      phy_rd_q  <= 1'b0;
      if (reg_done && mop == `SCHA_OP_READ && !m_ext && phy_reg_ok(reg_next)) begin
        phy_req_o        <= 1'b1;
        phy_we_o         <= 1'b0;
        phy_rd_q         <= 1'b1;
        phy_addr_field_o <= mphy;
        reg_addr_field_o <= reg_next;
      end else if (data_done && mop == `SCHA_OP_WRITE && !m_ext && phy_reg_ok(mreg)) begin
        phy_req_o        <= 1'b1;
        phy_we_o         <= 1'b1;
        phy_addr_field_o <= mphy;
        reg_addr_field_o <= mreg;
        phy_wdata_o      <= mrx_next;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mtx       <= 16'h0000;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      if (reg_done) begin
        mtx <= 16'h0000;
      end else if (rd_to_mdio) begin
        mtx <= {8'h00, rd_data};
      end else if (phy_rd_q) begin
        mtx <= phy_rdata_i;
      end else if (mdc_rise && mdio_oe_o && !data_done) begin
        mtx <= {mtx[14:0], 1'b0};
      end
      if (mdc_rise && mstate == mdio_st_ta && mbits == 4'h0 && mop == `SCHA_OP_READ) begin
        mdio_oe_o <= 1'b1;
        mdio_o    <= 1'b0;
      end else if (mdc_rise && mdio_oe_o) begin
        mdio_oe_o <= ~data_done;
        mdio_o    <= data_done ? 1'b0 : mtx[15];
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cmd_read;
    spi_done && spi_state == spi_st_cmd && spi_byte == `SCHA_CMD_READ;
  endsequence
  sequence s_ext_read_hdr;
    reg_done && mop == `SCHA_OP_READ && mphy[2:1] == `SCHA_EXT_SEL;
  endsequence

  property p_cmd_read;
    s_cmd_read |=> spi_state == spi_st_addr && spi_is_read;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("read command not decoded");

  property p_ss_end;
    (ss_n_s && spi_state == spi_st_data) |=> spi_state == spi_st_cmd && spi_bits == 3'h0 && !serial_data_out_oe_o;
  endproperty
  a_ss_end: assert property (p_ss_end) else $error("deselect did not end transfer");

  property p_incr;
    (spi_done && spi_state == spi_st_data) |=> spi_addr == 8'($past(spi_addr) + 8'h01);
  endproperty
  a_incr: assert property (p_incr) else $error("address did not advance");

  property p_wrap;
    (spi_done && spi_state == spi_st_data && spi_addr == 8'hff) |=> spi_addr == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_fall_launch;
    $changed(serial_data_out_o) |-> $past(sck_fall);
  endproperty
  a_fall_launch: assert property (p_fall_launch) else $error("output changed off falling edge");

  property p_start_hold;
    !init_done |-> !start_switch_o;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("switch started during hold");

  property p_init_time;
    (!init_done && init_cnt == 10'(`SCHA_INIT_CYCLES - 1)) |=> init_done ##1 $stable(init_done);
  endproperty
  a_init_time: assert property (p_init_time) else $error("start-up window length wrong");

  property p_ext_read;
    s_ext_read_hdr |=> mdio_pend && !mdio_we ##[0:2] rd_to_mdio;
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("extended read not issued");

  property p_ta_zero;
    $rose(mdio_oe_o) |-> !mdio_o && mstate == mdio_st_ta && mop == `SCHA_OP_READ;
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround drive wrong");

  property p_upper_zero;
    (mdio_oe_o && m_ext && mstate == mdio_st_data && mbits < 4'h8) |-> !mdio_o;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper data not zero");

  property p_release;
    (mstate != mdio_st_ta && mstate != mdio_st_data) |-> !mdio_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("MDIO driven outside read");

  property p_phy_only;
    phy_req_o |-> phy_reg_ok(reg_addr_field_o) && phy_addr_field_o[2:1] != `SCHA_EXT_SEL;
  endproperty
  a_phy_only: assert property (p_phy_only) else $error("PHY access to foreign register");

endmodule : scha_top

/* File: testbench/scha_host.sv */
// Host model driving the SPI and MDC/MDIO pins
`timescale 1ns/1ps

module scha_host (
  input  wire logic clock_i,
  input  wire logic miso_i,
  input  wire logic mdio_i,
  output logic      ss_n_o,
  output logic      sck_o,
  output logic      mosi_o,
  output logic      mdc_o,
  output logic      mdv_o,
  output logic      mdoe_o
);
  logic [7:0] d [4];
  // Pin clocks stand still high between frames
  initial begin
    {ss_n_o, sck_o, mosi_o, mdc_o, mdv_o, mdoe_o} = 6'h3c;
  end

  // ========
  // SPI
  // half period of 4 clocks
  task automatic half();
    repeat (4) @(negedge clock_i);
  endtask : half

  task automatic sbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      sck_o = 1'b0;
      mosi_o = tx[b];
      half();
      sck_o = 1'b1;
      rx = {rx[6:0], miso_i};
      half();
    end
  endtask : sbyte

  task automatic spi(input logic [7:0] cmd, input logic [7:0] addr, input int n);
    logic [7:0] r;
    ss_n_o = 1'b0;
    half();
    sbyte(cmd, r);
    sbyte(addr, r);
    for (int i = 0; i < n; i++) sbyte(d[i], d[i]);
    half();
    ss_n_o = 1'b1;
    half();
  endtask : spi

  // ========
  // MDIO
  // frame and turnaround
  task automatic mdio(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'h1, op, phy, rg, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      mdc_o = 1'b0;
      mdv_o = f[i];
      mdoe_o = (op == 2'h1) || (i > 17);
      half();
      rd = {rd[14:0], mdio_i};
      mdc_o = 1'b1;
      half();
    end
    // Idle gap so back-to-back frames never retoggle the enable in one step
    mdoe_o = 1'b0;
    half();
  endtask : mdio
endmodule : scha_host

/* File: testbench/switch_config_host_access_tb.sv */
// Self-checking bench of the host access block
`timescale 1ns/1ps
`include "scha_defs.svh"

module switch_config_host_access_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] rdat = 16'h0;
  logic        ss_n, sck, mosi, sdo, sdo_oe, mdc, mdv, mdoe, mdo, mdo_oe;
  logic        req, we, st, fast, rdy;
  logic [4:0]  pa, ra;
  logic [15:0] wdat, r16;
  logic [31:0] rnd = 32'hbe09;
  logic [7:0]  a, b0, b1;
  // SPI slave strap, moved off only in the last scenario
  logic [1:0]  strap = `SCHA_STRAP_SPI;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_req = 0;
  // Pull-up on the shared line
  wire         mdio = mdo_oe ? mdo : (mdoe ? mdv : 1'b1);
  // Released MISO shows the inverse of the last bit
  wire         miso = sdo_oe ? sdo : ~sdo;

  always #50 clk = ~clk;
  always @(posedge clk) if (req === 1'b1) n_req++;

  scha_top dut (.clock_i(clk), .rst_n_i(rst_n), .serial_port_strap_i(strap), .slave_select_n_i(ss_n),
    .serial_clock_in_i(sck), .serial_data_in_i(mosi), .serial_data_out_o(sdo), .serial_data_out_oe_o(sdo_oe),
    .mdc_i(mdc), .mdio_i(mdio), .mdio_o(mdo), .mdio_oe_o(mdo_oe), .phy_req_o(req), .phy_we_o(we),
    .phy_addr_field_o(pa), .reg_addr_field_o(ra), .phy_wdata_o(wdat), .phy_rdata_i(rdat),
    .start_switch_o(st), .spi_fast_o(fast), .config_ready_o(rdy));
  scha_host host (.clock_i(clk), .miso_i(miso), .mdio_i(mdio), .ss_n_o(ss_n), .sck_o(sck), .mosi_o(mosi),
    .mdc_o(mdc), .mdv_o(mdv), .mdoe_o(mdoe));

  // ========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 8; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr

  function automatic logic [4:0] ext_phy(input logic [7:0] i);
    return {i[7:6], 2'h3, i[5]};
  endfunction : ext_phy

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // ========
  // Scenarios
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (`SCHA_INIT_CYCLES - 10) @(negedge clk);
    chk({rdy, st}, 16'h0);
    repeat (20) @(negedge clk);
    chk({rdy, st}, 16'h2);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      a = k ? {1'b1, rnd[14:8]} : 8'hff;
      host.d[0] = rnd[7:0];
      host.d[1] = rnd[23:16];
      b0 = rnd[7:0];
      b1 = (a == 8'hff) ? 8'h5a : rnd[23:16];
      host.spi(`SCHA_CMD_WRITE, a, 2);
      host.spi(`SCHA_CMD_READ, a, 2);
      chk(host.d[0], b0);
      chk(host.d[1], b1);
    end
    host.d[0] = 8'h20;
    host.spi(8'h0b, `SCHA_IDX_GCTRL, 1);
    chk(fast, 16'h0);
    host.d[0] = 8'h20;
    host.spi(`SCHA_CMD_WRITE, `SCHA_IDX_GCTRL, 1);
    chk(fast, 16'h1);
    host.mdio(`SCHA_OP_READ, ext_phy(a), a[4:0], 16'h0, r16);
    chk(r16, {8'h00, b0});
    host.mdio(`SCHA_OP_WRITE, ext_phy(a), a[4:0], rnd[31:16], r16);
    host.spi(`SCHA_CMD_READ, a, 1);
    chk(host.d[0], rnd[23:16]);
    host.mdio(`SCHA_OP_WRITE, ext_phy(`SCHA_IDX_START), 5'h01, {rnd[15:8], 8'h41}, r16);
    chk(st, 16'h1);
    rdat = rnd[15:0];
    host.mdio(`SCHA_OP_READ, 5'h01, `SCHA_PHY_REG_1D, 16'h0, r16);
    chk(r16, rdat);
    host.mdio(`SCHA_OP_READ, 5'h01, 5'h06, 16'h0, r16);
    chk(r16, 16'h0);
    chk({we, pa, ra}, {1'b0, 5'h01, `SCHA_PHY_REG_1D});
    host.mdio(`SCHA_OP_WRITE, 5'h02, 5'h03, rnd[15:0], r16);
    chk({we, pa, ra}, {1'b1, 5'h02, 5'h03});
    chk(wdat, rnd[15:0]);
    chk(n_req, 16'h2);
    chk(mdo_oe, 16'h0);
    strap = 2'h0;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({rdy, st, fast, sdo, mdo_oe, req}, 16'h0);
    repeat (`SCHA_INIT_CYCLES + 10) @(negedge clk);
    host.d[0] = 8'h20;
    host.spi(`SCHA_CMD_WRITE, `SCHA_IDX_GCTRL, 1);
    chk(fast, 16'h0);
    stop_test();
  end

  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end
endmodule : switch_config_host_access_tb
